//--- src/papf_pkg.sv
// package: register map, fields, reset values and timing of the port a pullup block
package papf_pkg;
  localparam logic [15:0] PAPF_PULLUP_OFS = 16'h30f0;
  localparam logic [15:0] PAPF_FILTCFG_OFS = 16'h30f4;
  localparam logic [7:0] PAPF_PULLUP_RST = 8'h00;
  localparam logic [7:0] PAPF_PULLUP_WMASK = 8'hef;
  localparam int PAPF_RSVD_BIT = 4;
  localparam int PAPF_I2C_PIN_HI = 3;
  localparam int PAPF_I2C_PIN_LO = 2;
  localparam logic [1:0] PAPF_DIV1_RST = 2'h0;
  localparam int PAPF_DIV1_LSB = 0;
  localparam int PAPF_DIV_CNT_W = 4;
endpackage : papf_pkg

//--- src/papf_div_if.sv
// interface: divider setting and filter sample tick between top and divider
`timescale 1ns/10ps
`default_nettype none
interface papf_div_if;
  logic [1:0] sel;
  logic tick;
  modport ctrl (output sel, input tick);
  modport div (input sel, output tick);
endinterface : papf_div_if
`default_nettype wire

//--- src/papf_filter_div.sv
// filter clock divider: one-cycle tick every 2, 4, 8 or 16 bus cycles
`timescale 1ns/10ps
`default_nettype none
module papf_filter_div
  import papf_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // setting and tick
  papf_div_if.div dif
);
  logic [PAPF_DIV_CNT_W-1:0] cnt_q;
  logic [PAPF_DIV_CNT_W-1:0] lim;
  logic tick_q;

  // terminal count is 2^(sel+1)-1
  always_comb begin
    lim = PAPF_DIV_CNT_W'((5'h02 << dif.sel) - 5'h01); // R1
  end

  // free-running counter, restarts early if the setting shrinks
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q >= lim) begin
      cnt_q <= '0;
      tick_q <= 1'b1; // R1
    end else begin
      cnt_q <= cnt_q + 4'h1;
      tick_q <= 1'b0;
    end
  end
  assign dif.tick = tick_q;

  a_tick_spacing: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    tick_q && $stable(dif.sel) ##1 $stable(dif.sel)[*1] |-> !tick_q)
    else $error("filter tick repeats too soon");
endmodule : papf_filter_div
`default_nettype wire

//--- src/papf_top.sv
// top: port a pullup enable register, pullup control and input glitch filter
// Functional notes
// R1: divider set one gives bus clock over 2, 4, 8 or 16 per field code.
// R2: each enable bit set turns its pin pullup on, cleared turns it off.
// R3: enable bits have no effect on pins that are outputs or high impedance.
// R4: bit 4 of the enable register is read-only, ignores writes, reads zero.
// R5: pin 3 as i2c output keeps pullup while high, drops it while low.
// R6: pin 2 as i2c output keeps pullup while high, drops it while low.
// R7: glitches under one filter period are removed, over two periods pass.
// R8: writes land at the next edge; reads return stored bits, bit 4 zero.
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module papf_top
  import papf_pkg::*;
#(
  parameter int PINS = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pin state from the port logic
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_input_mode_in,
  input wire logic [PINS-1:0] pin_drive_low_in,
  input wire logic [PINS-1:0] pin_i2c_mode_in,
  // pullup control and filtered inputs
  output logic [PINS-1:0] pullup_on_out,
  output logic [PINS-1:0] pin_filtered_out
);
  logic [PINS-1:0] pull_en_q;
  logic [1:0] div1_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [PINS-1:0] pull_q;
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] samp_q;
  logic [PINS-1:0] filt_q;
  logic acc_setup;
  logic hit_pull;
  logic hit_cfg;
  logic [PINS-1:0] pull_d;
  logic [1:0] sel_prev_q;
  logic [4:0] gap_q;
  logic sel_moved_q;
  logic tick_seen_q;
  papf_div_if dif ();

  papf_filter_div u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .dif(dif)
  );
  assign dif.sel = div1_q;

  // decode; access completes one cycle after setup (one wait-free access phase)
  assign acc_setup = psel_in && !penable_in;
  assign hit_pull = paddr_in == PAPF_PULLUP_OFS;
  assign hit_cfg = paddr_in == PAPF_FILTCFG_OFS;

  // register writes, taken at the completing edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pull_en_q <= PAPF_PULLUP_RST;
      div1_q <= PAPF_DIV1_RST;
    end else if (psel_in && penable_in && pready_q && pwrite_in) begin
      if (hit_pull) begin
        pull_en_q <= pwdata_in[PINS-1:0] & PAPF_PULLUP_WMASK; // R4 R8
      end
      if (hit_cfg) begin
        div1_q <= pwdata_in[PAPF_DIV1_LSB+:2]; // R1
      end
    end
  end

  // apb answer: pready rises in the access phase; unmapped addresses error
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (acc_setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !(hit_pull || hit_cfg);
      if (!pwrite_in && hit_pull) begin
        prdata_q <= {24'h000000, pull_en_q & PAPF_PULLUP_WMASK}; // R4 R8
      end else if (!pwrite_in && hit_cfg) begin
        prdata_q <= {30'h00000000, div1_q};
      end else begin
        prdata_q <= '0;
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out = prdata_q;

  // pullup only on inputs, or on i2c pins driving high
  always_comb begin
    pull_d = pull_en_q & pin_input_mode_in; // R2 R3
    if (pin_i2c_mode_in[PAPF_I2C_PIN_HI] && !pin_drive_low_in[PAPF_I2C_PIN_HI]) begin
      pull_d[PAPF_I2C_PIN_HI] = pull_en_q[PAPF_I2C_PIN_HI]; // R5
    end
    if (pin_i2c_mode_in[PAPF_I2C_PIN_LO] && !pin_drive_low_in[PAPF_I2C_PIN_LO]) begin
      pull_d[PAPF_I2C_PIN_LO] = pull_en_q[PAPF_I2C_PIN_LO]; // R6
    end
  end

  // registered pullup drive
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pull_q <= '0;
    end else begin
      pull_q <= pull_d;
    end
  end
  assign pullup_on_out = pull_q;

  // two-stage synchroniser for the pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // sample per filter tick; output changes only after two equal samples,
  // so a level shorter than one tick period never gets through
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      samp_q <= '0;
      filt_q <= '0;
    end else if (dif.tick) begin
      samp_q <= sync2_q;
      for (int i = 0; i < PINS; i++) begin
        if (samp_q[i] == sync2_q[i]) begin
          filt_q[i] <= sync2_q[i]; // R7
        end
      end
    end
  end
  assign pin_filtered_out = filt_q;

  // divider code one cycle back, to spot a setting change
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sel_prev_q <= PAPF_DIV1_RST;
    end else begin
      sel_prev_q <= div1_q;
    end
  end

  // cycles since the last filter tick, for the period check only; a period in
  // which the code moved is skipped, as the divider restarts early or runs long then
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      gap_q <= 5'h01;
      sel_moved_q <= 1'b0;
      tick_seen_q <= 1'b0;
    end else if (dif.tick) begin
      gap_q <= 5'h01;
      sel_moved_q <= 1'b0;
      tick_seen_q <= 1'b1;
    end else begin
      if (gap_q != 5'h1f) begin
        gap_q <= gap_q + 5'h01; // saturates, never wraps into a false match
      end
      sel_moved_q <= sel_moved_q || (div1_q != sel_prev_q);
    end
  end

  a_rsvd_reads_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    pready_q |-> !prdata_q[PAPF_RSVD_BIT])
    else $error("reserved bit read nonzero");
  a_rsvd_stored_zero: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    !pull_en_q[PAPF_RSVD_BIT])
    else $error("reserved enable bit stored as one");
  a_write_lands: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    psel_in && penable_in && pready_q && pwrite_in && hit_pull |=>
    pull_en_q == ($past(pwdata_in[7:0]) & PAPF_PULLUP_WMASK))
    else $error("pullup write not stored");
  a_unmapped_err: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    acc_setup && !hit_pull && !hit_cfg |=> pready_q && pslverr_q && (prdata_q == 32'h00000000))
    else $error("unmapped access not refused");
  a_output_no_pull: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R3
    !pin_input_mode_in[0] |=> !pull_q[0])
    else $error("pullup on output pin");
  a_input_pull: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    pin_input_mode_in[7] |=> pull_q[7] == $past(pull_en_q[7]))
    else $error("pullup not following enable");
  a_i2c3_low: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    pin_i2c_mode_in[3] && pin_drive_low_in[3] && !pin_input_mode_in[3] |=> !pull_q[3])
    else $error("pin 3 pullup while driving low");
  a_i2c2_high: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    pin_i2c_mode_in[2] && !pin_drive_low_in[2] && pull_en_q[2] |=> pull_q[2])
    else $error("pin 2 pullup lost while high");
  a_ready_one: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    pready_q |=> !pready_q)
    else $error("pready longer than one cycle");
  a_filt_stable: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R7
    !dif.tick |=> $stable(filt_q))
    else $error("filter output changed off tick");
  a_tick_period: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    dif.tick && tick_seen_q && !sel_moved_q && (div1_q == sel_prev_q) |-> gap_q == (5'h02 << div1_q))
    else $error("filter tick period does not match the divider code");

  c_write_pull: cover property (@(posedge clk_in) pready_q && pwrite_in && hit_pull);
  c_read_pull: cover property (@(posedge clk_in) pready_q && !pwrite_in && hit_pull);
  c_filt_move: cover property (@(posedge clk_in) dif.tick ##1 $changed(filt_q));
  c_i2c_drop: cover property (@(posedge clk_in) pin_i2c_mode_in[PAPF_I2C_PIN_HI] && pin_drive_low_in[PAPF_I2C_PIN_HI]);
endmodule : papf_top
`default_nettype wire

//--- verification/tb_papf_top.sv
// testbench: apb access, pullup control and input filter of the port a pullup block
`timescale 1ns/10ps
`default_nettype none
module tb_papf_top;
  import papf_pkg::*;
  logic clk_in, rst_n_in, psel_in, penable_in, pwrite_in, pslverr_out, pready_out;
  logic [15:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [7:0] pin_in, pin_input_mode_in, pin_drive_low_in, pin_i2c_mode_in, pullup_on_out, pin_filtered_out;
  logic err;
  int n_mismatch = 0;
  int n_tests = 0;
  papf_top #(.PINS(8)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pin_in(pin_in),
    .pin_input_mode_in(pin_input_mode_in), .pin_drive_low_in(pin_drive_low_in),
    .pin_i2c_mode_in(pin_i2c_mode_in), .pullup_on_out(pullup_on_out), .pin_filtered_out(pin_filtered_out));
  // 10 mhz bus clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // one apb transfer; answer taken at the rising edge that sees pready, then released
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    // no assumed latency; only the watchdog ends a hang
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // set pin modes, let the registered pullup output settle, compare
  task automatic pull(input logic [7:0] im, input logic [7:0] dl, input logic [7:0] i2c, input logic [7:0] exp);
    @(posedge clk_in);
    pin_input_mode_in <= im;
    pin_drive_low_in <= dl;
    pin_i2c_mode_in <= i2c;
    repeat (3) @(negedge clk_in);
    chk(pullup_on_out, exp, "pullup");
  endtask
  task automatic t_regs;
    apb(1'b0, PAPF_PULLUP_OFS, 32'h0);
    chk(rd, 32'h0, "reset value");
    chk(err, 1'b0, "mapped read error");
    apb(1'b1, PAPF_PULLUP_OFS, 32'hffff_ffff);
    apb(1'b0, PAPF_PULLUP_OFS, 32'h0);
    chk(rd, 32'h0000_00ef, "bit 4 reads zero");
    apb(1'b1, 16'h3100, 32'h0000_0011);
    chk(err, 1'b1, "unmapped error");
    apb(1'b0, 16'h3100, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    $display("test regs done");
  endtask
  task automatic t_pull;
    pull(8'hff, 8'h00, 8'h00, 8'hef);
    pull(8'h0f, 8'h00, 8'h00, 8'h0f);
    pull(8'h00, 8'h08, 8'h0c, 8'h04);
    pull(8'h00, 8'h04, 8'h0c, 8'h08);
    apb(1'b1, PAPF_PULLUP_OFS, 32'h0000_0005);
    pull(8'hff, 8'h00, 8'h00, 8'h05);
    pull(8'h00, 8'h00, 8'h0c, 8'h04);
    pull(8'h00, 8'h00, 8'h00, 8'h00);
    $display("test pullup done");
  endtask
  // step delay pins down the filter period (two sync stages, then two agreeing
  // ticks); a glitch under one period must never show, a pulse over two must
  task automatic t_filt(input logic [1:0] code);
    int p, n;
    logic hit;
    p = 2 << code;
    n = 0;
    apb(1'b1, PAPF_FILTCFG_OFS, {30'h0, code});
    apb(1'b0, PAPF_FILTCFG_OFS, 32'h0);
    chk(rd, {30'h0, code}, "divider code readback");
    pin_in <= 8'h00;
    repeat (40) @(posedge clk_in);
    pin_in <= 8'hff;
    do begin
      @(negedge clk_in);
      n++;
    end while (pin_filtered_out !== 8'hff && n < 100);
    chk(n >= p + 4 && n <= 2 * p + 3, 1'b1, "filter step delay");
    @(posedge clk_in);
    pin_in <= 8'h00;
    repeat (40) @(posedge clk_in);
    pin_in <= 8'hff;
    repeat (p - 1) @(posedge clk_in);
    pin_in <= 8'h00;
    hit = 1'b0;
    repeat (40) begin
      @(negedge clk_in);
      if (pin_filtered_out !== 8'h00) hit = 1'b1;
    end
    chk(hit, 1'b0, "glitch removed");
    @(posedge clk_in);
    pin_in <= 8'hff;
    repeat (2 * p + 1) @(posedge clk_in);
    pin_in <= 8'h00;
    hit = 1'b0;
    repeat (40) begin
      @(negedge clk_in);
      if (pin_filtered_out === 8'hff) hit = 1'b1;
    end
    chk(hit, 1'b1, "long pulse passes");
    $display("test filter code %0d done", code);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // stimulus; reset held four cycles
  initial begin
    rst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 16'h0;
    pwdata_in = 32'h0;
    pin_in = 8'h00;
    pin_input_mode_in = 8'hff;
    pin_drive_low_in = 8'h00;
    pin_i2c_mode_in = 8'h00;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_pull();
    for (int c = 0; c < 4; c++) t_filt(c[1:0]);
    tally_and_finish();
  end
  // watchdog, far beyond the expected run of about nine hundred cycles
  initial begin
    #2000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_papf_top
`default_nettype wire
